// *** design/mpw_defs.svh ***
/*
 * Offsets, field positions, reset values and timing counts shared by the
 * motor PWM generator and the conversion trigger sequencer.
 * Assumes a 125 MHz peripheral clock and 32-bit APB data.
 */
`ifndef MPW_DEFS_SVH
`define MPW_DEFS_SVH

// counter range, signed 16 bit: -6250 .. 6249 gives 10 kHz at 125 MHz
`define MPW_CNT_INIT      16'hE796
`define MPW_CNT_END       16'h1869

// register byte offsets
`define MPW_OFS_CTRL      12'h000
`define MPW_OFS_RATIO     12'h004
`define MPW_OFS_DEADTIME  12'h008
`define MPW_OFS_TRIGCMP   12'h00C
`define MPW_OFS_DUTY0     12'h010
`define MPW_OFS_DUTY1     12'h014
`define MPW_OFS_DUTY2     12'h018
`define MPW_OFS_STATUS    12'h01C

// control fields
`define MPW_CTRL_RUN      0
`define MPW_CTRL_AUTOCLR  1
`define MPW_CTRL_XBAR     2
`define MPW_CTRL_SRST     3

// status fields
`define MPW_STAT_FAULT    0
`define MPW_STAT_FAULTIN  1
`define MPW_STAT_DONE_LSB 16

// reset values
`define MPW_RST_CTRL      4'h6
`define MPW_RST_RATIO     8'h01
`define MPW_RST_DEADTIME  8'h10
`define MPW_RST_TRIGCMP   16'h0008

// converter: 10-bit results, 3 conversions a chain, 13 converter clocks each
`define MPW_RES_BITS      10
`define MPW_CHAIN_LEN     2'h3
`define MPW_CONV_TICKS    4'hD

`endif

// *** design/mpw_link_if.sv ***
/*
 * Link between the PWM generator and the conversion trigger sequencer.
 * Assumes both ends run on the same pclk; the bench joins the ends.
 */
`timescale 1ns/1ps
interface mpw_link_if;
   logic trig;       // routed compare trigger, one-cycle pulse
   logic conv_done;  // end of a conversion chain, one-cycle pulse

   modport dev (output trig, input conv_done);
   modport seq (input trig, output conv_done);
endinterface

// *** design/mpw_pkg.sv ***
/*
 * Types for the motor PWM generator and its conversion sequencer.
 * Assumes mpw_defs.svh for all numeric constants.
 */
package mpw_pkg;
   typedef enum logic [0:0] {
      MPW_SEQ_IDLE,
      MPW_SEQ_CONV
   } mpw_seq_state_t;

   typedef logic signed [15:0] mpw_count_t;
endpackage

// *** design/mpw_pwm.sv ***
/*
 * Three-phase centre-aligned PWM generator with master reload, dead time,
 * fault shutdown, compare trigger and trigger routing, APB register slave.
 * Assumes pclk at 125 MHz, synchronous fault input, APB master with psel.
 */
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "mpw_defs.svh"

module mpw_pwm (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        fault_in,
   output logic      [2:0]  pwm_a,
   output logic      [2:0]  pwm_b,
   output logic             master_reload,
   mpw_link_if.dev          link
);
   logic [3:0]          ctrl;
   logic [7:0]          ratio;
   logic [7:0]          deadtime;
   mpw_pkg::mpw_count_t trig_cmp;
   mpw_pkg::mpw_count_t duty_reg [3];
   mpw_pkg::mpw_count_t duty_act [3];
   mpw_pkg::mpw_count_t cnt      [3];
   logic [7:0]          ratio_cnt;
   logic                fault_act;
   logic                trig_armed;
   logic                trig_pulse;
   logic [15:0]         done_cnt;
   logic                wr_ok;
   logic                srst;
   logic                wrap;
   logic                next_reload;
   logic [7:0]          ratio_last;

   assign wr_ok = psel && penable && pready && pwrite;
   assign srst  = ctrl[`MPW_CTRL_SRST];
   assign wrap  = (cnt[0] == mpw_pkg::mpw_count_t'(`MPW_CNT_END));
   // a ratio of zero is read as one so the master reload never stops
   assign ratio_last  = (ratio == 8'h00) ? 8'h00 : ratio - 8'h01;
   assign next_reload = ctrl[`MPW_CTRL_RUN] && wrap && (ratio_cnt == ratio_last);

   // apb access: one wait state, write lands at the edge pready is seen high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (psel && penable && !pready) begin
         pready  <= 1'b1;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         if (paddr == `MPW_OFS_CTRL) begin
            prdata <= {28'h000_0000, ctrl};
         end else if (paddr == `MPW_OFS_RATIO) begin
            prdata <= {24'h00_0000, ratio};
         end else if (paddr == `MPW_OFS_DEADTIME) begin
            prdata <= {24'h00_0000, deadtime};
         end else if (paddr == `MPW_OFS_TRIGCMP) begin
            prdata <= {16'h0000, trig_cmp};
         end else if (paddr == `MPW_OFS_DUTY0) begin
            prdata <= {16'h0000, duty_reg[0]};
         end else if (paddr == `MPW_OFS_DUTY1) begin
            prdata <= {16'h0000, duty_reg[1]};
         end else if (paddr == `MPW_OFS_DUTY2) begin
            prdata <= {16'h0000, duty_reg[2]};
         end else if (paddr == `MPW_OFS_STATUS) begin
            prdata <= {done_cnt, 14'h0000, fault_in, fault_act};
         end else begin
            pslverr <= 1'b1;
         end
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // soft reset bit clears itself one cycle after it is written
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl        <= `MPW_RST_CTRL;
         ratio       <= `MPW_RST_RATIO;
         deadtime    <= `MPW_RST_DEADTIME;
         trig_cmp    <= `MPW_RST_TRIGCMP;
         duty_reg[0] <= 16'h0000;
         duty_reg[1] <= 16'h0000;
         duty_reg[2] <= 16'h0000;
      end else if (wr_ok) begin
         ctrl[`MPW_CTRL_SRST] <= 1'b0;
         if (paddr == `MPW_OFS_CTRL) begin
            ctrl <= pwdata[3:0];
         end else if (paddr == `MPW_OFS_RATIO) begin
            ratio <= pwdata[7:0];
         end else if (paddr == `MPW_OFS_DEADTIME) begin
            deadtime <= pwdata[7:0];
         end else if (paddr == `MPW_OFS_TRIGCMP) begin
            trig_cmp <= pwdata[15:0];
         end else if (paddr == `MPW_OFS_DUTY0) begin
            duty_reg[0] <= pwdata[15:0];
         end else if (paddr == `MPW_OFS_DUTY1) begin
            duty_reg[1] <= pwdata[15:0];
         end else if (paddr == `MPW_OFS_DUTY2) begin
            duty_reg[2] <= pwdata[15:0];
         end
      end else begin
         ctrl[`MPW_CTRL_SRST] <= 1'b0;
      end
   end

   // reload opportunities counted in the master, counters all on pclk
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ratio_cnt     <= 8'h00;
         master_reload <= 1'b0;
      end else if (srst || !ctrl[`MPW_CTRL_RUN]) begin
         ratio_cnt     <= 8'h00;
         master_reload <= 1'b0;
      end else begin
         master_reload <= next_reload;
         if (next_reload) begin
            ratio_cnt <= 8'h00;
         end else if (wrap) begin
            ratio_cnt <= ratio_cnt + 8'h01;
         end
      end
   end

   // fault: blank while active, release at first reload after input drops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_act <= 1'b0;
      end else if (fault_in) begin
         fault_act <= 1'b1;
      end else if (srst) begin
         fault_act <= 1'b0;
      end else if (next_reload && ctrl[`MPW_CTRL_AUTOCLR]) begin
         fault_act <= 1'b0;
      end
   end

   // armed by the master reload, fires once at the compare match
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_armed <= 1'b0;
         trig_pulse <= 1'b0;
         link.trig  <= 1'b0;
      end else if (srst) begin
         trig_armed <= 1'b0;
         trig_pulse <= 1'b0;
         link.trig  <= 1'b0;
      end else begin
         if (next_reload) begin
            trig_armed <= 1'b1;
         end else if (trig_armed && cnt[0] == trig_cmp) begin
            trig_armed <= 1'b0;
         end
         trig_pulse <= trig_armed && !next_reload && (cnt[0] == trig_cmp);
         link.trig  <= trig_pulse && ctrl[`MPW_CTRL_XBAR];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_cnt <= 16'h0000;
      end else if (link.conv_done) begin
         done_cnt <= done_cnt + 16'h0001;
      end
   end

   for (genvar g = 0; g < 3; g++) begin : g_phase
      logic raw;
      logic raw_q;
      logic [7:0] dt_cnt;

      // centre-aligned: high while the count sits inside +/- duty
      assign raw = (cnt[g] >= -duty_act[g]) && (cnt[g] < duty_act[g]);

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            cnt[g]      <= `MPW_CNT_INIT;
            duty_act[g] <= 16'h0000;
         end else if (srst || !ctrl[`MPW_CTRL_RUN]) begin
            cnt[g] <= `MPW_CNT_INIT;
         end else begin
            if (next_reload) begin
               duty_act[g] <= duty_reg[g];
            end
            // slaves restart on the master reload, master on its own wrap
            if (next_reload || cnt[g] == mpw_pkg::mpw_count_t'(`MPW_CNT_END)) begin
               cnt[g] <= `MPW_CNT_INIT;
            end else begin
               cnt[g] <= cnt[g] + 16'sh0001;
            end
         end
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            raw_q    <= 1'b0;
            dt_cnt   <= 8'h00;
            pwm_a[g] <= 1'b0;
            pwm_b[g] <= 1'b0;
         end else if (srst || !ctrl[`MPW_CTRL_RUN]) begin
            raw_q    <= 1'b0;
            dt_cnt   <= deadtime;
            pwm_a[g] <= 1'b0;
            pwm_b[g] <= 1'b0;
         end else begin
            raw_q <= raw;
            if (raw != raw_q) begin
               dt_cnt <= deadtime;
            end else if (dt_cnt != 8'h00) begin
               dt_cnt <= dt_cnt - 8'h01;
            end
            // both sides low through the dead band and under fault
            pwm_a[g] <= raw_q && (raw == raw_q) && (dt_cnt == 8'h00) && !fault_act && !fault_in;
            pwm_b[g] <= !raw_q && (raw == raw_q) && (dt_cnt == 8'h00) && !fault_act && !fault_in;
         end
      end
   end
endmodule // mpw_pwm

// *** design/mpw_seq.sv ***
/*
 * Conversion trigger sequencer and converter model for the far end of the
 * PWM trigger link: three back-to-back conversions per trigger.
 * Assumes pclk at 125 MHz and sample values held steady by the user side.
 */
`timescale 1ns/1ps
`include "mpw_defs.svh"

module mpw_seq (
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   mpw_link_if.seq                      link,
   input  wire logic [`MPW_RES_BITS-1:0] sample_in [3],
   output logic      [`MPW_RES_BITS-1:0] result    [3],
   output logic                         conv_irq,
   output logic                         busy,
   output logic                         trig_missed,
   output logic                         adc_clk
);
   mpw_pkg::mpw_seq_state_t state;
   logic [1:0] idx;
   logic [3:0] ticks;
   logic       last_tick;

   assign last_tick = adc_clk && (ticks == `MPW_CONV_TICKS - 4'h1);

   // converter clock: pclk divided by two
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adc_clk <= 1'b0;
      end else begin
         adc_clk <= !adc_clk;
      end
   end

   // conversions start only from the link trigger, never from software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state          <= mpw_pkg::MPW_SEQ_IDLE;
         idx            <= 2'h0;
         ticks          <= 4'h0;
         busy           <= 1'b0;
         conv_irq       <= 1'b0;
         link.conv_done <= 1'b0;
         trig_missed    <= 1'b0;
      end else begin
         conv_irq       <= 1'b0;
         link.conv_done <= 1'b0;
         trig_missed    <= 1'b0;
         case (state)
            mpw_pkg::MPW_SEQ_IDLE: begin
               if (link.trig) begin
                  state <= mpw_pkg::MPW_SEQ_CONV;
                  idx   <= 2'h0;
                  ticks <= 4'h0;
                  busy  <= 1'b1;
               end
            end
            mpw_pkg::MPW_SEQ_CONV: begin
               // a trigger during a chain is dropped and reported
               trig_missed <= link.trig;
               if (adc_clk) begin
                  ticks <= last_tick ? 4'h0 : ticks + 4'h1;
               end
               if (last_tick) begin
                  if (idx == `MPW_CHAIN_LEN - 2'h1) begin
                     state          <= mpw_pkg::MPW_SEQ_IDLE;
                     busy           <= 1'b0;
                     conv_irq       <= 1'b1;
                     link.conv_done <= 1'b1;
                  end else begin
                     idx <= idx + 2'h1;
                  end
               end
            end
            default: begin
               state <= mpw_pkg::MPW_SEQ_IDLE;
            end
         endcase
      end
   end

   for (genvar g = 0; g < 3; g++) begin : g_res
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            result[g] <= 10'h000;
         end else if (state == mpw_pkg::MPW_SEQ_CONV && last_tick && idx == 2'(g)) begin
            result[g] <= sample_in[g];
         end
      end
   end
endmodule // mpw_seq

// *** test/mpw_link_bench.sv ***
/* Self-checking bench joining the PWM generator and the sequencer.
   Assumes the design files and mpw_defs.svh are compiled first. */
`timescale 1ns/1ps
`include "mpw_defs.svh"
module mpw_link_bench;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic        fault_in = 1'b0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, er, master_reload, conv_irq, busy, trig_missed, adc_clk;
   logic [2:0]  pwm_a, pwm_b, pa_q;
   logic [9:0]  sample_in [3];
   logic [9:0]  result [3];
   logic [29:0] q_smp [$];
   logic [29:0] smp;
   int          n_mismatch = 0, n_checks = 0, cyc = 0, last_rl = 0, trig_c = 0, n_done = 0;
   int          seed = 53875, ratio = 1, tcmp = 8, dt = 16, i, k;
   int          duty_pend [3], duty_act [3], rise_c [3];
   bit          gap_ok = 1'b0, w_en = 1'b0;
   logic [31:0] rst_tab [9] = '{32'h6, 32'h1, 32'h10, 32'h8, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

   mpw_link_if u_mpw_link_if ();
   mpw_pwm u_mpw_pwm (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .fault_in(fault_in), .pwm_a(pwm_a), .pwm_b(pwm_b),
      .master_reload(master_reload), .link(u_mpw_link_if));
   mpw_seq u_mpw_seq (.pclk(pclk), .presetn(presetn), .link(u_mpw_link_if),
      .sample_in(sample_in), .result(result), .conv_irq(conv_irq), .busy(busy),
      .trig_missed(trig_missed), .adc_clk(adc_clk));
   mpw_link_sva u_mpw_link_sva (.pclk(pclk), .presetn(presetn), .trig(u_mpw_link_if.trig),
      .conv_done(u_mpw_link_if.conv_done), .conv_irq(conv_irq), .busy(busy),
      .fault_in(fault_in), .master_reload(master_reload), .pwm_a(pwm_a), .pwm_b(pwm_b),
      .trig_missed(trig_missed), .adc_clk(adc_clk));

   always #4 pclk = ~pclk;

   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task near(input int got, input int exp, input int tol, input string what);
      n_checks++;
      if (got < exp - tol || got > exp + tol) begin
         n_mismatch++;
         $display("BAD %0t %s got %0d expected %0d", $time, what, got, exp);
      end
   endtask

   task finish_test;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int j;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (j = 0; j < 20 && pready !== 1'b1; j++) @(posedge pclk);
      if (pready !== 1'b1) begin
         n_mismatch++;
         finish_test;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wait_rl;
      int j;
      for (j = 0; j < 30000; j++) begin
         @(posedge pclk);
         if (master_reload === 1'b1) return;
      end
      n_mismatch++;
      finish_test;
   endtask

   // reference model: reload spacing, trigger delay, chain results, pulse widths
   always @(posedge pclk) begin
      cyc = cyc + 1;
      if (master_reload === 1'b1) begin
         if (gap_ok) near(cyc - last_rl, 12500 * ratio, 0, "reload gap");
         last_rl = cyc;
         duty_act = duty_pend;
         rise_c = '{-1, -1, -1};
      end
      if (u_mpw_link_if.trig === 1'b1) begin
         near(cyc - last_rl, 6251 + tcmp, 2, "trigger delay");
         q_smp.push_back({sample_in[2], sample_in[1], sample_in[0]});
         trig_c = cyc;
      end
      if (u_mpw_link_if.conv_done === 1'b1) begin
         n_done++;
         near(cyc - trig_c, 78, 2, "chain time");
         smp = (q_smp.size() > 0) ? q_smp.pop_front() : 30'h0;
         for (k = 0; k < 3; k++) begin
            chk({22'h0, result[k]}, {22'h0, smp[k*10 +: 10]}, "result");
         end
      end
      // fresh samples only between chains so each chain sees steady inputs
      if (cyc == 1 || u_mpw_link_if.conv_done === 1'b1) begin
         for (k = 0; k < 3; k++) sample_in[k] <= 10'($random(seed));
      end
      for (k = 0; k < 3; k++) begin
         if (pwm_a[k] === 1'b1 && pa_q[k] === 1'b0) rise_c[k] = cyc;
         if (pwm_a[k] === 1'b0 && pa_q[k] === 1'b1 && rise_c[k] >= 0 && w_en)
            near(cyc - rise_c[k], 2 * duty_act[k] - dt - 1, 2, "high width");
      end
      pa_q = pwm_a;
   end

   initial begin
      pa_q = 3'h0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      for (i = 0; i < 9; i++) begin
         apb(1'b0, 12'(i * 4), 32'h0);
         chk(rd, rst_tab[i], "reset value");
         chk({31'h0, er}, {31'h0, i == 8}, "slave error");
      end
      apb(1'b1, `MPW_OFS_STATUS, 32'hFFFF_FFFF);
      apb(1'b0, `MPW_OFS_STATUS, 32'h0);
      chk(rd, 32'h0, "status read only");
      for (i = 0; i < 3; i++) begin
         duty_pend[i] = 400 + ($random(seed) & 32'h7FF);
         apb(1'b1, `MPW_OFS_DUTY0 + 12'(i * 4), 32'(duty_pend[i]));
      end
      apb(1'b1, `MPW_OFS_DEADTIME, 32'h0000_0014);
      apb(1'b0, `MPW_OFS_DEADTIME, 32'h0);
      chk(rd, 32'h0000_0014, "dead time write");
      dt = 20;
      apb(1'b1, `MPW_OFS_CTRL, 32'h7);
      w_en = 1'b1;
      wait_rl;
      @(negedge pclk) gap_ok = 1'b1;
      wait_rl;
      // change duty and compare point mid-period: width follows at reload only
      repeat (200) @(posedge pclk);
      duty_pend[0] = 3000;
      apb(1'b1, `MPW_OFS_DUTY0, 32'h0000_0BB8);
      apb(1'b1, `MPW_OFS_TRIGCMP, 32'h0000_0064);
      tcmp = 100;
      wait_rl;
      @(negedge pclk) gap_ok = 1'b0;
      ratio = 2;
      apb(1'b1, `MPW_OFS_RATIO, 32'h2);
      wait_rl;
      @(negedge pclk) gap_ok = 1'b1;
      repeat (10000) @(posedge pclk);
      w_en = 1'b0;
      fault_in <= 1'b1;
      repeat (3) @(posedge pclk);
      chk({26'h0, pwm_a, pwm_b}, 32'h0, "fault blank");
      apb(1'b0, `MPW_OFS_STATUS, 32'h0);
      chk(rd, {16'(n_done), 14'h0, 2'b11}, "status in fault");
      fault_in <= 1'b0;
      repeat (5) @(posedge pclk);
      chk({26'h0, pwm_a, pwm_b}, 32'h0, "held until reload");
      wait_rl;
      repeat (30) @(posedge pclk);
      chk({26'h0, pwm_a, pwm_b}, 32'h0000_0007, "recovered");
      apb(1'b0, `MPW_OFS_STATUS, 32'h0);
      chk(rd, {16'(n_done), 16'h0}, "fault cleared");
      // soft reset clears the fault latch without waiting for a reload
      fault_in <= 1'b1;
      repeat (3) @(posedge pclk);
      fault_in <= 1'b0;
      apb(1'b1, `MPW_OFS_CTRL, 32'h0000_000F);
      apb(1'b0, `MPW_OFS_CTRL, 32'h0);
      chk(rd, 32'h0000_0007, "soft reset self clear");
      apb(1'b0, `MPW_OFS_STATUS, 32'h0);
      chk(rd, {16'(n_done), 16'h0}, "soft reset fault");
      repeat (30) @(posedge pclk);
      chk({26'h0, pwm_a, pwm_b}, 32'h0000_0007, "soft reset outputs");
      finish_test;
   end
endmodule // mpw_link_bench

// *** test/mpw_link_sva.sv ***
/* Checker for the PWM generator and sequencer pair: link pulses, output
   pairs, fault blanking, chain timing. Assumes one pclk domain and that
   the bench wires it beside mpw_link_if. */
`timescale 1ns/1ps
module mpw_link_sva (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       trig,
   input wire logic       conv_done,
   input wire logic       conv_irq,
   input wire logic       busy,
   input wire logic       fault_in,
   input wire logic       master_reload,
   input wire logic [2:0] pwm_a,
   input wire logic [2:0] pwm_b,
   input wire logic       trig_missed,
   input wire logic       adc_clk
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_trig_pulse: assert property (trig |=> !trig)
      else $error("trigger wider than one cycle");
   chk_no_overlap: assert property ((pwm_a & pwm_b) == 3'h0)
      else $error("both switches of a phase on");
   // dead time is at least 8 cycles in every bench setting
   chk_dead_ab: assert property ($fell(pwm_b[0]) |-> (!pwm_a[0]) [*8])
      else $error("high side on too soon");
   chk_dead_ba: assert property ($fell(pwm_a[1]) |-> (!pwm_b[1]) [*8])
      else $error("low side on too soon");
   chk_fault_blank: assert property (fault_in |=> pwm_a == 3'h0 && pwm_b == 3'h0)
      else $error("outputs live during fault");
   chk_reload_pulse: assert property (master_reload |=> (!master_reload) [*8])
      else $error("reload pulses too close");
   chk_irq_done: assert property (conv_done == conv_irq)
      else $error("irq and chain end differ");
   chk_trig_start: assert property (trig && !busy |=> busy)
      else $error("trigger did not start a chain");
   chk_chain_time: assert property ($rose(busy) |-> ##[74:82] conv_done)
      else $error("chain did not end in time");
   chk_drop_only_busy: assert property (!(trig && busy) |=> !trig_missed)
      else $error("trigger reported dropped while idle");
   // the first edge after release still sees the reset value, so it is skipped
   chk_adc_div: assert property (!$past(presetn) || adc_clk != $past(adc_clk))
      else $error("converter clock is not pclk over two");
   cover property (trig);
   cover property (conv_done);
   cover property (fault_in ##1 fault_in);
endmodule // mpw_link_sva
